// *** logic/mask_cmd_pkg.sv ***
package mask_cmd_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_FW_CMD_MASK = 8'h1F;
  localparam logic [7:0] ADDR_SUPPLY_TEMP_MASK = 8'h20;
  localparam logic [7:0] ADDR_AUX_ONE_TWO_MASK = 8'h21;
  localparam logic [7:0] ADDR_AUX_THREE_VENDOR_MASK = 8'h22;
  localparam logic [7:0] ADDR_RESERVED_MASK = 8'h23;
  localparam logic [7:0] ADDR_VENDOR_CUSTOM_MASK = 8'h24;
  localparam logic [7:0] ADDR_CMD_STATE_ONE = 8'h25;
  localparam logic [7:0] ADDR_CMD_STATE_TWO = 8'h26;
  localparam logic [7:0] ADDR_CMD_OVERLAP = 8'h27;
  localparam logic [7:0] ADDR_IRQ_SUMMARY = 8'h28;
  // ----------------------------------------
  // writable bits and reset values
  // ----------------------------------------
  localparam logic [7:0] FW_CMD_WRITABLE = 8'hC7;
  localparam logic [7:0] FULL_WRITABLE = 8'hFF;
  localparam logic [7:0] RESERVED_WRITABLE = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int STATE_CHANGE_BIT = 0;
  localparam int UNIT_FW_BIT = 1;
  localparam int LANE_FW_BIT = 2;
  localparam int CMD_ONE_BIT = 6;
  localparam int CMD_TWO_BIT = 7;
  localparam int WORKING_BIT = 7;
  localparam int ERROR_BIT = 6;
  localparam int OVERLAP_ONE_BIT = 0;
  localparam int OVERLAP_TWO_BIT = 1;
  // ----------------------------------------
  // in-progress result codes
  // ----------------------------------------
  localparam logic [5:0] RESULT_CAPTURED = 6'h01;
  localparam logic [5:0] RESULT_CHECKING = 6'h02;
  localparam logic [5:0] RESULT_EXECUTING = 6'h03;

  typedef enum {PHASE_IDLE, PHASE_CAPTURED, PHASE_CHECKING, PHASE_EXECUTING} cmd_phase_t;

  // only advertised bits take the written value; the rest stay zero
  function automatic logic [7:0] maskWrite(input logic [7:0] data, input logic [7:0] writable);
    return data & writable;
  endfunction
endpackage

// *** logic/block_links_if.sv ***
`timescale 1ns/1ns
interface cmd_status_if;
  logic trigger;
  logic advance;
  logic finish;
  logic failed;
  logic [5:0] result;
  logic [7:0] status;
  modport engine(output trigger, output advance, output finish, output failed, output result, input status);
  modport tracker(input trigger, input advance, input finish, input failed, input result, output status);
endinterface

interface irq_gate_if;
  logic [39:0] flags;
  logic [39:0] masks;
  logic irq;
  modport source(output flags, output masks, input irq);
  modport gate(input flags, input masks, output irq);
endinterface

// *** logic/cmd_status_tracker.sv ***
`timescale 1ns/1ns
module cmd_status_tracker (
  input wire logic core_clk,
  input wire logic srst,
  cmd_status_if.tracker link
);
  mask_cmd_pkg::cmd_phase_t phase_q;
  logic [7:0] status_q;
  logic working;

  assign working = status_q[mask_cmd_pkg::WORKING_BIT];
  assign link.status = status_q;

  // ----------------------------------------
  // phase sequence
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      phase_q <= mask_cmd_pkg::PHASE_IDLE;
    end else if (link.trigger) begin
      phase_q <= mask_cmd_pkg::PHASE_CAPTURED;
    end else if (link.finish && working) begin
      phase_q <= mask_cmd_pkg::PHASE_IDLE;
    end else if (link.advance) begin
      unique case (phase_q)
        mask_cmd_pkg::PHASE_CAPTURED: phase_q <= mask_cmd_pkg::PHASE_CHECKING;
        mask_cmd_pkg::PHASE_CHECKING: phase_q <= mask_cmd_pkg::PHASE_EXECUTING;
        mask_cmd_pkg::PHASE_EXECUTING: phase_q <= mask_cmd_pkg::PHASE_EXECUTING;
        mask_cmd_pkg::PHASE_IDLE: phase_q <= mask_cmd_pkg::PHASE_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // status byte
  // ----------------------------------------
  // a new trigger beats a finish in the same cycle: the byte tracks the latest command
  always_ff @(posedge core_clk) begin
    if (srst) begin
      status_q <= mask_cmd_pkg::STATUS_RESET;
    end else if (link.trigger) begin
      // [R18] busy on trigger
      status_q <= {1'b1, 1'b0, mask_cmd_pkg::RESULT_CAPTURED};
    end else if (link.finish && working) begin
      // [R14] failed after completion
      status_q <= {1'b0, link.failed, link.result};
    end else if (link.advance && phase_q == mask_cmd_pkg::PHASE_CAPTURED) begin
      // [R17] checking code
      status_q <= {1'b1, 1'b0, mask_cmd_pkg::RESULT_CHECKING};
    end else if (link.advance && phase_q == mask_cmd_pkg::PHASE_CHECKING) begin
      status_q <= {1'b1, 1'b0, mask_cmd_pkg::RESULT_EXECUTING};
    end
  end
endmodule

// *** logic/irq_mask_gate.sv ***
`timescale 1ns/1ns
module irq_mask_gate (
  input wire logic core_clk,
  input wire logic srst,
  irq_gate_if.gate link
);
  logic irq_q;

  assign link.irq = irq_q;

  // ----------------------------------------
  // interrupt gating
  // ----------------------------------------
  // flags keep latching outside; a set mask only hides them from the pin
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_q <= 1'b0;
    end else begin
      // [R19] mask suppresses flag
      irq_q <= |(link.flags & ~link.masks);
    end
  end
endmodule

// *** logic/module_mask_and_cmd_status.sv ***
`timescale 1ns/1ns
// Contract
// [R1] host-writable mask bits decide which module flags may raise the interrupt
// [R2] offset 1Fh bit 0 masks state change; always present, read-write
// [R3] offset 1Fh bits 1 and 2 mask unit and lane firmware faults
// [R4] offset 1Fh bits 6, 7 mask command done one, two; bits 5-3 reserved
// [R5] offset 20h: supply masks high nibble, temperature masks low nibble
// [R6] offset 21h: auxiliary two high nibble, auxiliary one low nibble
// [R7] offset 22h: vendor monitor high nibble, auxiliary three low nibble
// [R8] offset 23h reserved; offset 24h holds vendor module-level masks
// [R9] each command block instance keeps its own status byte of latest command
// [R10] read-only status of instance one at 25h, instance two at 26h
// [R11] status reads answer while a command still executes, showing progress
// [R12] in foreground mode the host reads status only after completion
// [R13] bit 7 high while busy; host waits before a new command
// [R14] bit 6 after completion: zero success, one failure
// [R15] bits 5-0 hold result code interpreted by the coarse status
// [R16] busy means in progress; idle with fail clear success, set failure
// [R17] progress codes 01h captured, 02h checking, 03h executing
// [R18] busy bit set as soon as a command is triggered
// [R19] set mask hides a flag from the interrupt, flag still latches
// [R20] unsupported bits read zero; writes to reserved bits do nothing
module module_mask_and_cmd_status (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [7:0] regRdData,
  input wire logic [7:0] fwCmdFlags,
  input wire logic [7:0] supplyTempFlags,
  input wire logic [7:0] auxOneTwoFlags,
  input wire logic [7:0] auxThreeVendorFlags,
  input wire logic [7:0] vendorCustomFlags,
  output logic irqOut,
  input wire logic cmdOneTrigger,
  input wire logic cmdOneAdvance,
  input wire logic cmdOneFinish,
  input wire logic cmdOneFailed,
  input wire logic [5:0] cmdOneResult,
  output logic cmdOneWorking,
  input wire logic cmdTwoTrigger,
  input wire logic cmdTwoAdvance,
  input wire logic cmdTwoFinish,
  input wire logic cmdTwoFailed,
  input wire logic [5:0] cmdTwoResult,
  output logic cmdTwoWorking
);
  // ----------------------------------------
  // mask storage
  // ----------------------------------------
  // masks reset to zero, so every flag may interrupt until the host sets a bit
  logic [7:0] fwCmdMask_q;
  logic [7:0] supplyTempMask_q;
  logic [7:0] auxOneTwoMask_q;
  logic [7:0] auxThreeVendorMask_q;
  logic [7:0] vendorCustomMask_q;

  // ----------------------------------------
  // own status and read path
  // ----------------------------------------
  logic [1:0] overlap_q;
  logic [1:0] overlap_d;
  logic [7:0] rdData_q;
  logic [7:0] rdData_d;
  logic wrHit;
  logic overlapOneSet;
  logic overlapTwoSet;

  // ----------------------------------------
  // named mask fields
  // ----------------------------------------
  logic state_change_irq_block;
  logic unit_fw_fault_irq_block;
  logic lane_fw_fault_irq_block;
  logic cmd_done_one_irq_block;
  logic cmd_done_two_irq_block;
  logic [7:0] fwCmdLive;
  logic [7:0] fwCmdGateMask;

  // ----------------------------------------
  // sub-block links
  // ----------------------------------------
  cmd_status_if cmdOneLink();
  cmd_status_if cmdTwoLink();
  irq_gate_if irqLink();

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  // one place qualifies every register write, so a new register cannot skip the strobe check
  function automatic logic writeHit(input logic hit, input logic [7:0] addr, input logic [7:0] target);
    return hit && (addr == target);
  endfunction

  // busy bit test, shared by the pins and the overlap record
  function automatic logic isWorking(input logic [7:0] status);
    return status[mask_cmd_pkg::WORKING_BIT];
  endfunction

  // ----------------------------------------
  // write selects
  // ----------------------------------------
  logic wrFwCmd;
  logic wrSupplyTemp;
  logic wrAuxOneTwo;
  logic wrAuxThreeVendor;
  logic wrVendorCustom;
  logic wrOverlap;

  // a cycle with both strobes high is taken as a read; the write is dropped
  assign wrHit = regWrStb && !regRdStb;
  assign wrFwCmd = writeHit(wrHit, regAddr, mask_cmd_pkg::ADDR_FW_CMD_MASK);
  assign wrSupplyTemp = writeHit(wrHit, regAddr, mask_cmd_pkg::ADDR_SUPPLY_TEMP_MASK);
  assign wrAuxOneTwo = writeHit(wrHit, regAddr, mask_cmd_pkg::ADDR_AUX_ONE_TWO_MASK);
  assign wrAuxThreeVendor = writeHit(wrHit, regAddr, mask_cmd_pkg::ADDR_AUX_THREE_VENDOR_MASK);
  assign wrVendorCustom = writeHit(wrHit, regAddr, mask_cmd_pkg::ADDR_VENDOR_CUSTOM_MASK);
  assign wrOverlap = writeHit(wrHit, regAddr, mask_cmd_pkg::ADDR_CMD_OVERLAP);

  assign state_change_irq_block = fwCmdMask_q[mask_cmd_pkg::STATE_CHANGE_BIT];
  assign unit_fw_fault_irq_block = fwCmdMask_q[mask_cmd_pkg::UNIT_FW_BIT];
  assign lane_fw_fault_irq_block = fwCmdMask_q[mask_cmd_pkg::LANE_FW_BIT];
  assign cmd_done_one_irq_block = fwCmdMask_q[mask_cmd_pkg::CMD_ONE_BIT];
  assign cmd_done_two_irq_block = fwCmdMask_q[mask_cmd_pkg::CMD_TWO_BIT];

  // ----------------------------------------
  // firmware and command masks
  // ----------------------------------------
  // reserved bits 5-3 are dropped on write, so they always read zero
  always_ff @(posedge core_clk) begin
    if (srst) begin
      fwCmdMask_q <= mask_cmd_pkg::MASK_RESET;
    end else if (wrFwCmd) begin
      // [R2] state change mask
      // [R3] firmware fault masks
      // [R4] command done masks
      fwCmdMask_q <= mask_cmd_pkg::maskWrite(regWrData, mask_cmd_pkg::FW_CMD_WRITABLE);
    end
  end

  // ----------------------------------------
  // supply and temperature masks
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      supplyTempMask_q <= mask_cmd_pkg::MASK_RESET;
    end else if (wrSupplyTemp) begin
      // [R5] supply and temperature
      supplyTempMask_q <= mask_cmd_pkg::maskWrite(regWrData, mask_cmd_pkg::FULL_WRITABLE);
    end
  end

  // ----------------------------------------
  // auxiliary one and two masks
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      auxOneTwoMask_q <= mask_cmd_pkg::MASK_RESET;
    end else if (wrAuxOneTwo) begin
      // [R6] auxiliary one and two
      auxOneTwoMask_q <= mask_cmd_pkg::maskWrite(regWrData, mask_cmd_pkg::FULL_WRITABLE);
    end
  end

  // ----------------------------------------
  // auxiliary three and vendor monitor masks
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      auxThreeVendorMask_q <= mask_cmd_pkg::MASK_RESET;
    end else if (wrAuxThreeVendor) begin
      // [R7] auxiliary three, vendor
      auxThreeVendorMask_q <= mask_cmd_pkg::maskWrite(regWrData, mask_cmd_pkg::FULL_WRITABLE);
    end
  end

  // ----------------------------------------
  // vendor module-level masks
  // ----------------------------------------
  // the reserved byte has no storage at all; writes there fall away
  always_ff @(posedge core_clk) begin
    if (srst) begin
      vendorCustomMask_q <= mask_cmd_pkg::MASK_RESET;
    end else if (wrVendorCustom) begin
      // [R8] vendor mask byte
      vendorCustomMask_q <= mask_cmd_pkg::maskWrite(regWrData, mask_cmd_pkg::FULL_WRITABLE);
    end
  end

  // ----------------------------------------
  // interrupt gate
  // ----------------------------------------
  // unsupported bits 5-3 never reach the gate, whatever the outside latch shows
  assign fwCmdLive = fwCmdFlags & mask_cmd_pkg::FW_CMD_WRITABLE;
  // the gate's copy of offset 1Fh is rebuilt from the named fields, so each flag meets its own mask
  assign fwCmdGateMask = {cmd_done_two_irq_block, cmd_done_one_irq_block, 3'h0, lane_fw_fault_irq_block,
                          unit_fw_fault_irq_block, state_change_irq_block};
  // [R1] masks steer interrupt
  assign irqLink.flags = {vendorCustomFlags, auxThreeVendorFlags, auxOneTwoFlags, supplyTempFlags, fwCmdLive};
  assign irqLink.masks = {vendorCustomMask_q, auxThreeVendorMask_q, auxOneTwoMask_q, supplyTempMask_q,
                          fwCmdGateMask};
  assign irqOut = irqLink.irq;

  irq_mask_gate irqGate (
    .core_clk(core_clk),
    .srst(srst),
    .link(irqLink)
  );

  // ----------------------------------------
  // command block instances
  // ----------------------------------------
  // [R9] independent status per instance
  assign cmdOneLink.trigger = cmdOneTrigger;
  assign cmdOneLink.advance = cmdOneAdvance;
  assign cmdOneLink.finish = cmdOneFinish;
  assign cmdOneLink.failed = cmdOneFailed;
  assign cmdOneLink.result = cmdOneResult;
  assign cmdTwoLink.trigger = cmdTwoTrigger;
  assign cmdTwoLink.advance = cmdTwoAdvance;
  assign cmdTwoLink.finish = cmdTwoFinish;
  assign cmdTwoLink.failed = cmdTwoFailed;
  assign cmdTwoLink.result = cmdTwoResult;

  cmd_status_tracker cmdOneTracker (
    .core_clk(core_clk),
    .srst(srst),
    .link(cmdOneLink)
  );

  cmd_status_tracker cmdTwoTracker (
    .core_clk(core_clk),
    .srst(srst),
    .link(cmdTwoLink)
  );

  // ----------------------------------------
  // instance status bytes
  // ----------------------------------------
  // host reads, busy pins and the overlap record all see the same byte, so they never disagree
  logic [7:0] cmdOneStatus;
  logic [7:0] cmdTwoStatus;

  assign cmdOneStatus = cmdOneLink.status;
  assign cmdTwoStatus = cmdTwoLink.status;

  // [R13] busy bit out
  assign cmdOneWorking = isWorking(cmdOneStatus);
  assign cmdTwoWorking = isWorking(cmdTwoStatus);

  // ----------------------------------------
  // overlapping trigger record
  // ----------------------------------------
  // a trigger while busy breaks the host's wait duty; it is recorded, not blocked,
  // because the engine owns the command and decides how to treat it
  assign overlapOneSet = cmdOneTrigger && isWorking(cmdOneStatus);
  assign overlapTwoSet = cmdTwoTrigger && isWorking(cmdTwoStatus);

  always_comb begin
    overlap_d = overlap_q;
    if (wrOverlap) begin
      overlap_d = overlap_q & ~regWrData[1:0];
    end
    // set beats a clear in the same cycle
    if (overlapOneSet) begin
      overlap_d[mask_cmd_pkg::OVERLAP_ONE_BIT] = 1'b1;
    end
    if (overlapTwoSet) begin
      overlap_d[mask_cmd_pkg::OVERLAP_TWO_BIT] = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      overlap_q <= 2'h0;
    end else begin
      overlap_q <= overlap_d;
    end
  end

  // ----------------------------------------
  // read decode
  // ----------------------------------------
  always_comb begin
    rdData_d = mask_cmd_pkg::READ_IDLE;
    if (regRdStb) begin
      unique case (regAddr)
        mask_cmd_pkg::ADDR_FW_CMD_MASK: begin
          // [R20] reserved read zero
          rdData_d = fwCmdMask_q;
        end
        mask_cmd_pkg::ADDR_SUPPLY_TEMP_MASK: begin
          rdData_d = supplyTempMask_q;
        end
        mask_cmd_pkg::ADDR_AUX_ONE_TWO_MASK: begin
          rdData_d = auxOneTwoMask_q;
        end
        mask_cmd_pkg::ADDR_AUX_THREE_VENDOR_MASK: begin
          rdData_d = auxThreeVendorMask_q;
        end
        mask_cmd_pkg::ADDR_RESERVED_MASK: begin
          // nothing is stored here; the read is forced to zero
          rdData_d = mask_cmd_pkg::maskWrite(8'hFF, mask_cmd_pkg::RESERVED_WRITABLE);
        end
        mask_cmd_pkg::ADDR_VENDOR_CUSTOM_MASK: begin
          rdData_d = vendorCustomMask_q;
        end
        mask_cmd_pkg::ADDR_CMD_STATE_ONE: begin
          // [R10] instance one status
          // [R11] live progress read
          // [R15] result code
          // [R16] coarse encoding
          rdData_d = cmdOneStatus;
        end
        mask_cmd_pkg::ADDR_CMD_STATE_TWO: begin
          rdData_d = cmdTwoStatus;
        end
        mask_cmd_pkg::ADDR_CMD_OVERLAP: begin
          // sticky until written with ones; the engine keeps running regardless
          rdData_d = {6'h00, overlap_q};
        end
        mask_cmd_pkg::ADDR_IRQ_SUMMARY: begin
          // lets polling firmware see the pin level without wiring it back
          rdData_d = {7'h00, irqLink.irq};
        end
        default: begin
          rdData_d = mask_cmd_pkg::READ_IDLE;
        end
      endcase
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdData_q <= mask_cmd_pkg::READ_IDLE;
    end else begin
      rdData_q <= rdData_d;
    end
  end

  assign regRdData = rdData_q;
endmodule

// *** bench/mask_cmd_props.sv ***
`timescale 1ns/1ns
module mask_cmd_props (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] regAddr,
  input wire logic regRdStb,
  input wire logic [7:0] regRdData,
  input wire logic [7:0] fwCmdFlags,
  input wire logic [7:0] supplyTempFlags,
  input wire logic [7:0] auxOneTwoFlags,
  input wire logic [7:0] auxThreeVendorFlags,
  input wire logic [7:0] vendorCustomFlags,
  input wire logic irqOut,
  input wire logic cmdOneTrigger,
  input wire logic cmdOneFinish,
  input wire logic cmdOneWorking,
  input wire logic cmdTwoTrigger,
  input wire logic cmdTwoWorking
);
  logic anyFlag;
  // fw bits 5-3 carry no flag, so they never count as a cause
  assign anyFlag = |{fwCmdFlags[7:6], fwCmdFlags[2:0], supplyTempFlags, auxOneTwoFlags,
                     auxThreeVendorFlags, vendorCustomFlags};
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  AST_READ_IDLE: assert property (!regRdStb |=> regRdData == 8'h00)
    else $error("read data not zero outside read cycle");
  AST_RSVD_ZERO: assert property (regRdStb && regAddr == 8'h23 |=> regRdData == 8'h00)
    else $error("reserved mask byte reads nonzero");
  AST_FW_RSVD_BITS: assert property (regRdStb && regAddr == 8'h1F |=> regRdData[5:3] == 3'h0)
    else $error("reserved bits of fw mask read nonzero");
  AST_ONE_BUSY_READ: assert property (regRdStb && regAddr == 8'h25 |=> regRdData[7] == $past(cmdOneWorking))
    else $error("status one busy bit differs from working");
  AST_TWO_BUSY_READ: assert property (regRdStb && regAddr == 8'h26 |=> regRdData[7] == $past(cmdTwoWorking))
    else $error("status two busy bit differs from working");
  AST_ONE_TRIG: assert property (cmdOneTrigger |=> cmdOneWorking)
    else $error("trigger one did not set busy");
  AST_TWO_TRIG: assert property (cmdTwoTrigger |=> cmdTwoWorking)
    else $error("trigger two did not set busy");
  AST_ONE_DONE: assert property (cmdOneFinish && cmdOneWorking && !cmdOneTrigger |=> !cmdOneWorking)
    else $error("finish one left busy set");
  AST_ONE_HOLD: assert property (!cmdOneTrigger && !cmdOneFinish |=> cmdOneWorking == $past(cmdOneWorking))
    else $error("busy one changed without event");
  AST_IRQ_CAUSE: assert property (irqOut |-> $past(anyFlag))
    else $error("interrupt without any flag");
  cover property (cmdOneTrigger ##[1:20] cmdOneFinish);
  cover property ($rose(irqOut));
  cover property (regRdStb && regAddr == 8'h26);
endmodule

bind module_mask_and_cmd_status mask_cmd_props i_mask_cmd_props (.core_clk, .srst, .regAddr, .regRdStb,
  .regRdData, .fwCmdFlags, .supplyTempFlags, .auxOneTwoFlags, .auxThreeVendorFlags, .vendorCustomFlags,
  .irqOut, .cmdOneTrigger, .cmdOneFinish, .cmdOneWorking, .cmdTwoTrigger, .cmdTwoWorking);

// *** bench/host_mgmt_model.sv ***
`timescale 1ns/1ns
module host_mgmt_model (
  input wire logic core_clk,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrStb,
  output logic regRdStb,
  input wire logic [7:0] regRdData
);
  initial begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrStb = 1'b0;
    regRdStb = 1'b0;
  end
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge core_clk);
    regWrStb <= 1'b0;
  endtask
  // data taken in the one cycle it stands
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge core_clk);
    regRdStb <= 1'b0;
    #1 d = regRdData;
  endtask
endmodule

// *** bench/module_mask_and_cmd_status_tb.sv ***
`timescale 1ns/1ns
module module_mask_and_cmd_status_tb;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] regAddr, regWrData, regRdData;
  logic regWrStb, regRdStb, irqOut;
  logic [7:0] flags [5];
  logic [1:0] trig = 2'h0, adv = 2'h0, fin = 2'h0, bad = 2'h0;
  wire [1:0] working;
  logic [5:0] res [2];
  logic [7:0] addrs [8] = '{8'h1F, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26};
  logic [7:0] keep [8] = '{8'hC7, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00};
  logic [7:0] irqAddr [5] = '{8'h1F, 8'h20, 8'h21, 8'h22, 8'h24};
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;

  always #25 core_clk = ~core_clk;

  host_mgmt_model i_host_mgmt_model (.core_clk(core_clk), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData));

  module_mask_and_cmd_status i_module_mask_and_cmd_status (.core_clk(core_clk), .srst(srst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .fwCmdFlags(flags[0]), .supplyTempFlags(flags[1]), .auxOneTwoFlags(flags[2]),
    .auxThreeVendorFlags(flags[3]), .vendorCustomFlags(flags[4]), .irqOut(irqOut),
    .cmdOneTrigger(trig[0]), .cmdOneAdvance(adv[0]), .cmdOneFinish(fin[0]), .cmdOneFailed(bad[0]),
    .cmdOneResult(res[0]), .cmdOneWorking(working[0]), .cmdTwoTrigger(trig[1]), .cmdTwoAdvance(adv[1]),
    .cmdTwoFinish(fin[1]), .cmdTwoFailed(bad[1]), .cmdTwoResult(res[1]), .cmdTwoWorking(working[1]));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_host_mgmt_model.read_reg(a, d);
    chk(d, exp);
  endtask

  task automatic settle();
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  // one event pulse: {trigger, advance, finish} with outcome and code
  task automatic cmd_step(input int k, input logic [2:0] taf, input logic fl, input logic [5:0] code);
    @(posedge core_clk);
    trig[k] <= taf[2];
    adv[k] <= taf[1];
    fin[k] <= taf[0];
    bad[k] <= fl;
    res[k] <= code;
    @(posedge core_clk);
    trig[k] <= 1'b0;
    adv[k] <= 1'b0;
    fin[k] <= 1'b0;
  endtask

  task automatic test_reset_values();
    for (int a = 'h1F; a <= 'h28; a++) rd_chk(8'(a), 8'h00);
    rd_chk(8'h40, 8'h00);
    $display("test reset values done");
  endtask

  task automatic test_mask_rw();
    for (int i = 0; i < 8; i++) begin
      i_host_mgmt_model.write_reg(addrs[i], 8'hFF);
      rd_chk(addrs[i], keep[i]);
      i_host_mgmt_model.write_reg(addrs[i], 8'h5A);
      rd_chk(addrs[i], 8'h5A & keep[i]);
      i_host_mgmt_model.write_reg(addrs[i], 8'h00);
    end
    $display("test mask access done");
  endtask

  task automatic test_irq();
    logic e;
    for (int i = 0; i < 5; i++) begin
      for (int b = 0; b < 8; b++) begin
        e = (i == 0) ? keep[0][b] : 1'b1;
        @(posedge core_clk);
        flags[i] <= 8'h01 << b;
        settle();
        chk({7'h00, irqOut}, {7'h00, e});
        rd_chk(8'h28, {7'h00, e});
        i_host_mgmt_model.write_reg(irqAddr[i], 8'h01 << b);
        settle();
        chk({7'h00, irqOut}, 8'h00);
        i_host_mgmt_model.write_reg(irqAddr[i], 8'h00);
        @(posedge core_clk);
        flags[i] <= 8'h00;
        settle();
      end
    end
    $display("test interrupt masking done");
  endtask

  task automatic test_cmd(input int k);
    logic [7:0] sa;
    sa = 8'h25 + 8'(k);
    // check that the instance is idle before the first trigger
    chk({7'h00, working[k]}, 8'h00);
    cmd_step(k, 3'b100, 1'b0, 6'h00);
    rd_chk(sa, 8'h81);
    chk({7'h00, working[k]}, 8'h01);
    cmd_step(k, 3'b100, 1'b0, 6'h00);
    rd_chk(8'h27, 8'h01 << k);
    i_host_mgmt_model.write_reg(8'h27, 8'h03);
    rd_chk(8'h27, 8'h00);
    rd_chk(sa, 8'h81);
    cmd_step(k, 3'b010, 1'b0, 6'h00);
    rd_chk(sa, 8'h82);
    cmd_step(k, 3'b010, 1'b0, 6'h00);
    rd_chk(sa, 8'h83);
    cmd_step(k, 3'b010, 1'b0, 6'h00);
    rd_chk(sa, 8'h83);
    cmd_step(k, 3'b001, 1'b0, 6'h01);
    rd_chk(sa, 8'h01);
    chk({7'h00, working[k]}, 8'h00);
    cmd_step(k, 3'b001, 1'b1, 6'h05);
    rd_chk(sa, 8'h01);
    cmd_step(k, 3'b100, 1'b0, 6'h00);
    cmd_step(k, 3'b001, 1'b1, 6'h02);
    rd_chk(sa, 8'h42);
    rd_chk(8'h25 + 8'(1 - k), (k == 0) ? 8'h00 : 8'h42);
    cmd_step(k, 3'b101, 1'b0, 6'h01);
    rd_chk(sa, 8'h81);
    cmd_step(k, 3'b001, 1'b0, 6'h3F);
    rd_chk(sa, 8'h3F);
    cmd_step(k, 3'b100, 1'b0, 6'h00);
    cmd_step(k, 3'b001, 1'b1, 6'h02);
    $display("test command instance %0d done", k + 1);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      complete_run();
    end
  end

  initial begin
    flags = '{default: 8'h00};
    res = '{default: 6'h00};
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    test_reset_values();
    test_mask_rw();
    test_irq();
    test_cmd(0);
    test_cmd(1);
    complete_run();
  end
endmodule
